// *** rtl/adc_context_control.sv ***
// asynchronous dma context control, status and command pointers
// Operation
// - run changes by hardware only on reset
// - wake resumes; cleared on a descriptor fetch unless a wake set write comes in the same cycle
// - dead set on fatal error while running, cleared when run clears
// - active high while descriptors are processed
// - speed codes 000/001/010 for 100/200/400
// - speed meaningful only for receive contexts
// - event field holds ack or error code
// - reserved control bits read as zero
// - run start fetches from command pointer
// - pointer bits 31:4 hold aligned block address
// - pointer bits 3:0 count; zero means invalid
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
module adc_context_control
	import adc_pkg::*;
(
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	input  wire logic        soft_rst,
	// register port
	input  wire logic [11:0] reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// descriptor engine side, one bit per context except the shared pkt_speed and pkt_event
	output logic      [3:0]  ctx_start,
	output logic      [3:0]  ctx_run,
	output logic      [3:0]  ctx_wake,
	input  wire logic [3:0]  desc_fetch,
	input  wire logic [3:0]  ctx_busy,
	input  wire logic [3:0]  fatal_err,
	input  wire logic [3:0]  pkt_done,
	input  wire logic [2:0]  pkt_speed,
	input  wire logic [4:0]  pkt_event,
	// pointer of each context
	output logic      [31:0] cmd_ptr_tx_req,
	output logic      [31:0] cmd_ptr_tx_resp,
	output logic      [31:0] cmd_ptr_rx_req,
	output logic      [31:0] cmd_ptr_rx_resp,
	output logic      [3:0]  ptr_valid,
	// interrupt
	output logic             irq
);
	import adc_pkg::*;

	// ************************************************************
	// address decode
	// ************************************************************

	// base of each context window
	function automatic logic [11:0] ctx_base(input int c);
		unique case (c)
			0:       ctx_base = ADC_REQ_TX_SET;
			1:       ctx_base = ADC_RESP_TX_SET;
			2:       ctx_base = ADC_REQ_RX_SET;
			default: ctx_base = ADC_RESP_RX_SET;
		endcase
	endfunction

	// offset within window for set, clear and pointer
	localparam logic [11:0] OFS_CLR = ADC_REQ_TX_CLR - ADC_REQ_TX_SET;
	localparam logic [11:0] OFS_PTR = ADC_REQ_TX_PTR - ADC_REQ_TX_SET;

	logic [3:0]  run;          // run bits
	logic [3:0]  wake;         // wake bits
	logic [3:0]  dead;         // dead bits
	logic [3:0]  active;       // active bits
	logic [2:0]  spd    [4];   // speed of last packet
	logic [4:0]  evt    [4];   // event code
	logic [31:0] ptr    [4];   // command pointers
	logic [3:0]  hit_set;      // write to set address
	logic [3:0]  hit_clr;      // write to clear address
	logic [3:0]  hit_ptr;      // write to pointer
	logic [3:0]  int_status;   // sticky fatal events
	logic [3:0]  int_mask;     // interrupt mask
	logic [3:0]  run_q;        // run one cycle ago

	// ************************************************************
	// per-context control
	// ************************************************************
	genvar g;
	generate
		for (g = 0; g < ADC_NUM_CTX; g++)
		begin : gen_ctx
			// strobes for this context
			assign hit_set[g] = reg_wr && (reg_addr == ctx_base(g));
			assign hit_clr[g] = reg_wr && (reg_addr == ctx_base(g) + OFS_CLR);
			assign hit_ptr[g] = reg_wr && (reg_addr == ctx_base(g) + OFS_PTR);

			// run: only software or reset changes it
			always_ff @(posedge clk_sys or posedge sys_rst)
			begin
				if (sys_rst)
					run[g] <= 1'b0;
				else if (soft_rst)
					run[g] <= 1'b0;
				else if (hit_set[g] && reg_wdata[ADC_RUN_BIT])
					run[g] <= 1'b1;
				else if (hit_clr[g] && reg_wdata[ADC_RUN_BIT])
					run[g] <= 1'b0;
			end

			// wake: software sets, fetch clears; set wins
			always_ff @(posedge clk_sys or posedge sys_rst)
			begin
				if (sys_rst)
					wake[g] <= 1'b0;
				else if (soft_rst)
					wake[g] <= 1'b0;
				else if (hit_set[g] && reg_wdata[ADC_WAKE_BIT])
					wake[g] <= 1'b1;
				else if (desc_fetch[g])
					wake[g] <= 1'b0;
			end

			// dead: fatal error while running sets, run low clears
			always_ff @(posedge clk_sys or posedge sys_rst)
			begin
				if (sys_rst)
					dead[g] <= 1'b0;
				else if (fatal_err[g] && run[g])
					dead[g] <= 1'b1;
				else if (!run[g])
					dead[g] <= 1'b0;
			end

			// active follows engine; status never software written
			always_ff @(posedge clk_sys or posedge sys_rst)
			begin
				if (sys_rst)
					active[g] <= 1'b0;
				else
					active[g] <= ctx_busy[g] && run[g] && !dead[g];
			end

			// speed and event latched at packet completion
			always_ff @(posedge clk_sys or posedge sys_rst)
			begin
				if (sys_rst)
				begin
					spd[g] <= ADC_SPD_100;
					evt[g] <= 5'h00;
				end
				else if (pkt_done[g])
				begin
					// transmit contexts keep speed zero
					spd[g] <= (g >= 2) ? pkt_speed : ADC_SPD_100;
					evt[g] <= pkt_event;
				end
			end

			// command pointer, software owned
			always_ff @(posedge clk_sys or posedge sys_rst)
			begin
				if (sys_rst)
					ptr[g] <= ADC_PTR_RESET;
				else if (hit_ptr[g])
					ptr[g] <= reg_wdata;
			end

			// engine outputs
			assign ctx_run[g]   = run[g];
			assign ctx_wake[g]  = wake[g];
			assign ctx_start[g] = run[g] && !run_q[g];
			assign ptr_valid[g] = (ptr[g][ADC_PTR_ADDR_LSB-1:0] != 4'h0);
		end
	endgenerate

	// rising edge of run starts a fetch
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			run_q <= 4'h0;
		else
			run_q <= run;
	end

	// pointers to the descriptor engine
	assign cmd_ptr_tx_req  = ptr[0];
	assign cmd_ptr_tx_resp = ptr[1];
	assign cmd_ptr_rx_req  = ptr[2];
	assign cmd_ptr_rx_resp = ptr[3];

	// ************************************************************
	// interrupts
	// ************************************************************

	// sticky fatal events, write one to clear, set wins
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			int_status <= 4'h0;
		else if (reg_wr && reg_addr == ADC_INT_STATUS)
			int_status <= (int_status & ~reg_wdata[3:0]) | (fatal_err & run);
		else
			int_status <= int_status | (fatal_err & run);
	end

	// mask register
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			int_mask <= 4'h0;
		else if (reg_wr && reg_addr == ADC_INT_MASK)
			int_mask <= reg_wdata[3:0];
	end

	assign irq = |(int_status & int_mask);

	// ************************************************************
	// read path
	// ************************************************************

	// control word with reserved bits at zero
	function automatic logic [31:0] ctl_word(input int c);
		logic [31:0] w;
		w = ADC_ZERO;
		w[ADC_RUN_BIT]    = run[c];
		w[ADC_WAKE_BIT]   = wake[c];
		w[ADC_DEAD_BIT]   = dead[c];
		w[ADC_ACTIVE_BIT] = active[c];
		w[ADC_SPD_LSB+:3] = spd[c];
		w[ADC_EVT_LSB+:5] = evt[c];
		ctl_word = w;
	endfunction

	logic [31:0] next_rdata;   // decoded read value

	// combinational decode, unmapped reads zero
	always_comb
	begin
		next_rdata = ADC_ZERO;
		for (int c = 0; c < ADC_NUM_CTX; c++)
		begin
			if (reg_addr == ctx_base(c) || reg_addr == ctx_base(c) + OFS_CLR)
				next_rdata = ctl_word(c);
			else if (reg_addr == ctx_base(c) + OFS_PTR)
				next_rdata = ptr[c];
		end
		if (reg_addr == ADC_INT_STATUS)
			next_rdata = {28'h000_0000, int_status};
		else if (reg_addr == ADC_INT_MASK)
			next_rdata = {28'h000_0000, int_mask};
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			reg_rdata <= ADC_ZERO;
		else if (reg_rd)
			reg_rdata <= next_rdata;
		else
			reg_rdata <= ADC_ZERO;
	end

	// ************************************************************
	// assertions
	// ************************************************************
	a_run_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(!reg_wr && !soft_rst) |=> $stable(run))
		else $error("run changed without write or reset");

	a_wake_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(desc_fetch[0] && !hit_set[0]) |=> !wake[0])
		else $error("wake not cleared on fetch");

	a_dead_set: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(fatal_err[1] && run[1]) |=> dead[1])
		else $error("dead not set on fatal error");

	a_dead_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(!run[2]) |=> !dead[2])
		else $error("dead stays while run clear");

	a_active_busy: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(ctx_busy[3] && run[3] && !dead[3]) |=> active[3])
		else $error("active low while processing");

	a_tx_speed: assert property (@(posedge clk_sys) disable iff (sys_rst)
		spd[0] == ADC_SPD_100 && spd[1] == ADC_SPD_100)
		else $error("transmit speed field not zero");

	a_rx_event: assert property (@(posedge clk_sys) disable iff (sys_rst)
		pkt_done[2] |=> (evt[2] == $past(pkt_event) && spd[2] == $past(pkt_speed)))
		else $error("receive event or speed not captured");

	a_reserved_zero: assert property (@(posedge clk_sys) disable iff (sys_rst)
		$past(reg_rd) && $past(reg_addr) == ADC_REQ_TX_SET |->
		(reg_rdata[31:16] == 16'h0000 && reg_rdata[14:13] == 2'h0 && reg_rdata[9:8] == 2'h0))
		else $error("reserved bits not zero");

	a_start_pulse: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(hit_set[0] && reg_wdata[ADC_RUN_BIT] && !run[0] && !soft_rst) |=>
		ctx_start[0] ##1 !ctx_start[0])
		else $error("start pulse missing");

	a_status_ro: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(hit_set[1] && !pkt_done[1]) |=> $stable(evt[1]))
		else $error("software altered event field");

	// ************************************************************
	// per-context checks, one copy for each context
	// ************************************************************
	generate
		for (g = 0; g < ADC_NUM_CTX; g++)
		begin : gen_chk
			// run never rises without a set write
			a_run_still: assert property (@(posedge clk_sys) disable iff (sys_rst)
				(!hit_set[g] && !run[g]) |=> !run[g])
				else $error("run rose without a set write");

			// run never falls without a clear write or soft reset
			a_run_keep: assert property (@(posedge clk_sys) disable iff (sys_rst)
				(run[g] && !soft_rst && !hit_clr[g]) |=> run[g])
				else $error("run fell without a clear write");

			// software wake request beats a fetch in the same cycle
			a_wake_set: assert property (@(posedge clk_sys) disable iff (sys_rst)
				(hit_set[g] && reg_wdata[ADC_WAKE_BIT] && !soft_rst) |=> wake[g])
				else $error("wake not set by software");

			// fetch drops wake when no set write competes
			a_wake_fetch: assert property (@(posedge clk_sys) disable iff (sys_rst)
				(desc_fetch[g] && !hit_set[g]) |=> !wake[g])
				else $error("wake kept after fetch");

			// dead only leaves once run is low
			a_dead_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
				(dead[g] && run[g]) |=> dead[g])
				else $error("dead fell while running");

			// fatal event stays pending until written off
			a_int_sticky: assert property (@(posedge clk_sys) disable iff (sys_rst)
				(int_status[g] && !(reg_wr && reg_addr == ADC_INT_STATUS)) |=> int_status[g])
				else $error("pending fatal event lost");

			// active drops when the engine idles, halts or dies
			a_active_idle: assert property (@(posedge clk_sys) disable iff (sys_rst)
				(!ctx_busy[g] || !run[g] || dead[g]) |=> !active[g])
				else $error("active high while idle");

			// completion event only moves on packet completion
			a_evt_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
				!pkt_done[g] |=> $stable(evt[g]))
				else $error("event field moved without a packet");

			// control word keeps reserved bits at zero
			a_ctl_reserved: assert property (@(posedge clk_sys) disable iff (sys_rst)
				($past(reg_rd) && $past(reg_addr) == ctx_base(g) + OFS_CLR) |->
				(reg_rdata[31:16] == 16'h0000 && reg_rdata[14:13] == 2'h0 && reg_rdata[9:8] == 2'h0))
				else $error("reserved control bits not zero");

			// start is a single-cycle pulse
			a_start_once: assert property (@(posedge clk_sys) disable iff (sys_rst)
				ctx_start[g] |=> !ctx_start[g])
				else $error("start pulse longer than one cycle");

			// pointer takes the written word whole
			a_ptr_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
				hit_ptr[g] |=> (ptr[g] == $past(reg_wdata)))
				else $error("pointer write lost");

			// software cannot raise dead
			a_dead_quiet: assert property (@(posedge clk_sys) disable iff (sys_rst)
				(!fatal_err[g] && !dead[g]) |=> !dead[g])
				else $error("dead rose without a fatal error");
		end
	endgenerate
endmodule

// *** rtl/adc_pkg.sv ***
// constants for the asynchronous dma context control block
package adc_pkg;
	// ************************************************************
	// register offsets (byte addresses)
	// ************************************************************
	localparam logic [11:0] ADC_REQ_TX_SET   = 12'h0180;
	localparam logic [11:0] ADC_REQ_TX_CLR   = 12'h0184;
	localparam logic [11:0] ADC_REQ_TX_PTR   = 12'h018c;
	localparam logic [11:0] ADC_RESP_TX_SET  = 12'h01a0;
	localparam logic [11:0] ADC_RESP_TX_CLR  = 12'h01a4;
	localparam logic [11:0] ADC_RESP_TX_PTR  = 12'h01ac;
	localparam logic [11:0] ADC_REQ_RX_SET   = 12'h01c0;
	localparam logic [11:0] ADC_REQ_RX_CLR   = 12'h01c4;
	localparam logic [11:0] ADC_REQ_RX_PTR   = 12'h01cc;
	localparam logic [11:0] ADC_RESP_RX_SET  = 12'h01e0;
	localparam logic [11:0] ADC_RESP_RX_CLR  = 12'h01e4;
	localparam logic [11:0] ADC_RESP_RX_PTR  = 12'h01ec;
	// interrupt registers
	localparam logic [11:0] ADC_INT_STATUS   = 12'h0170;
	localparam logic [11:0] ADC_INT_MASK     = 12'h0174;
	// ************************************************************
	// control register fields
	// ************************************************************
	localparam int ADC_RUN_BIT    = 15;
	localparam int ADC_WAKE_BIT   = 12;
	localparam int ADC_DEAD_BIT   = 11;
	localparam int ADC_ACTIVE_BIT = 10;
	localparam int ADC_SPD_LSB    = 5;
	localparam int ADC_EVT_LSB    = 0;
	// pointer fields
	localparam int ADC_PTR_ADDR_LSB = 4;
	// speed codes
	localparam logic [2:0] ADC_SPD_100 = 3'h0;
	localparam logic [2:0] ADC_SPD_200 = 3'h1;
	localparam logic [2:0] ADC_SPD_400 = 3'h2;
	// reset values
	localparam logic [31:0] ADC_PTR_RESET = 32'h0000_0000;
	localparam logic [31:0] ADC_ZERO      = 32'h0000_0000;
	// number of contexts
	localparam int ADC_NUM_CTX = 4;
endpackage

// *** test/test_adc_context_control.sv ***
// self-checking bench for the async dma context control block
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
	$display("ERROR %0t: got %h expected %h", $time, (g), (e)); end end
module test_adc_context_control;
	import adc_pkg::*;
	// ************************************************************
	// signals
	// ************************************************************
	logic        clk_sys, sys_rst, soft_rst;  // clock and resets
	logic [11:0] reg_addr;                    // register port
	logic [31:0] reg_wdata, reg_rdata;        // write and read data
	logic        reg_wr, reg_rd, irq;         // strobes and interrupt
	logic [3:0]  ctx_start, ctx_run, ctx_wake; // per-context outputs
	logic [3:0]  desc_fetch, ctx_busy, fatal_err, pkt_done, ptr_valid;
	logic [2:0]  pkt_speed;                   // speed of last packet
	logic [4:0]  pkt_event, ev;               // event code in and expected
	logic [31:0] cmd_ptr_tx_req, cmd_ptr_tx_resp; // transmit pointer outputs
	logic [31:0] cmd_ptr_rx_req, cmd_ptr_rx_resp; // receive pointer outputs
	logic [31:0] ptr_o [4];                   // pointer outputs by context
	logic [31:0] exp_v;                       // expected register word
	int          n_errors, n_compared, i, k;  // counters and loop indices
	localparam logic [11:0] SET_A [4] = '{ADC_REQ_TX_SET, ADC_RESP_TX_SET,
		ADC_REQ_RX_SET, ADC_RESP_RX_SET};
	localparam logic [2:0]  SPD [3]   = '{ADC_SPD_100, ADC_SPD_200, ADC_SPD_400};
	localparam logic [31:0] RUN  = 32'h0000_0001 << ADC_RUN_BIT;
	localparam logic [31:0] WAKE = 32'h0000_0001 << ADC_WAKE_BIT;
	localparam logic [31:0] DEAD = 32'h0000_0001 << ADC_DEAD_BIT;
	localparam logic [31:0] ACT  = 32'h0000_0001 << ADC_ACTIVE_BIT;
	assign ptr_o[0] = cmd_ptr_tx_req;
	assign ptr_o[1] = cmd_ptr_tx_resp;
	assign ptr_o[2] = cmd_ptr_rx_req;
	assign ptr_o[3] = cmd_ptr_rx_resp;
	// ************************************************************
	// design and clock
	// ************************************************************
	adc_context_control u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .soft_rst(soft_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .ctx_start(ctx_start), .ctx_run(ctx_run),
		.ctx_wake(ctx_wake), .desc_fetch(desc_fetch), .ctx_busy(ctx_busy),
		.fatal_err(fatal_err), .pkt_done(pkt_done), .pkt_speed(pkt_speed),
		.pkt_event(pkt_event), .cmd_ptr_tx_req(cmd_ptr_tx_req),
		.cmd_ptr_tx_resp(cmd_ptr_tx_resp), .cmd_ptr_rx_req(cmd_ptr_rx_req),
		.cmd_ptr_rx_resp(cmd_ptr_rx_resp), .ptr_valid(ptr_valid), .irq(irq));
	// 40 MHz system clock
	initial
	begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	// ************************************************************
	// access tasks
	// ************************************************************
	// one-cycle write strobe, returns just after the taking edge
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		#1;
	endtask
	// one-cycle read strobe, data checked in the cycle after it
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		`CHK(reg_rdata, e)
	endtask
	// one-cycle pulse on an engine-side input or on soft_rst
	task automatic pulse(input int sel, input logic [3:0] v);
		@(posedge clk_sys);
		case (sel)
			0: desc_fetch <= v;
			1: fatal_err <= v;
			2: pkt_done <= v;
			default: soft_rst <= v[0];
		endcase
		@(posedge clk_sys);
		desc_fetch <= 4'h0;
		fatal_err <= 4'h0;
		pkt_done <= 4'h0;
		soft_rst <= 1'b0;
		#1;
	endtask
	// counts, verdict and end of run
	task automatic give_verdict();
		$display("compared %0d, errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// watchdog far beyond the expected run length
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		n_errors++;
		give_verdict();
	end
	// ************************************************************
	// tests
	// ************************************************************
	initial
	begin
		{soft_rst, reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
		{desc_fetch, ctx_busy, fatal_err, pkt_done, pkt_speed, pkt_event} = '0;
		n_errors = 0;
		n_compared = 0;
		sys_rst = 1'b1;
		repeat (8) @(posedge clk_sys);
		sys_rst <= 1'b0;
		for (i = 0; i < 4; i++)
		begin
			rd_chk(SET_A[i], ADC_ZERO);
			rd_chk(SET_A[i] + 12'h00c, ADC_PTR_RESET);
		end
		$display("test reset done");
		// set all ones, only run and wake take; wake falls on fetch
		for (i = 0; i < 4; i++)
		begin
			wr(SET_A[i], 32'hffff_ffff);
			`CHK(ctx_start, 4'h1 << i)
			`CHK(ctx_run, 4'h1 << i)
			`CHK(ctx_wake, 4'h1 << i)
			@(posedge clk_sys);
			#1;
			`CHK(ctx_start, 4'h0)
			rd_chk(SET_A[i], RUN | WAKE);
			rd_chk(SET_A[i] + 12'h004, RUN | WAKE);
			pulse(0, 4'h1 << i);
			`CHK(ctx_wake, 4'h0)
			rd_chk(SET_A[i], RUN);
			wr(SET_A[i] + 12'h004, 32'hffff_ffff);
			rd_chk(SET_A[i], ADC_ZERO);
		end
		$display("test set clear done");
		// fatal error sets dead and interrupt; halting clears dead
		for (i = 0; i < 4; i++)
		begin
			wr(SET_A[i], RUN);
			pulse(1, 4'h1 << i);
			rd_chk(SET_A[i], RUN | DEAD);
			rd_chk(ADC_INT_STATUS, {28'h000_0000, 4'h1 << i});
			`CHK(irq, 1'b0)
			wr(ADC_INT_MASK, {28'h000_0000, 4'h1 << i});
			`CHK(irq, 1'b1)
			wr(ADC_INT_STATUS, {28'h000_0000, 4'h1 << i});
			`CHK(irq, 1'b0)
			wr(SET_A[i] + 12'h004, RUN);
			rd_chk(SET_A[i], ADC_ZERO);
		end
		$display("test dead done");
		// active follows the engine while running
		wr(SET_A[3], RUN);
		@(posedge clk_sys);
		ctx_busy <= 4'h8;
		rd_chk(SET_A[3], RUN | ACT);
		@(posedge clk_sys);
		ctx_busy <= 4'h0;
		rd_chk(SET_A[3], RUN);
		wr(SET_A[3] + 12'h004, RUN);
		$display("test active done");
		// speed and event capture, speed only on receive contexts
		for (i = 0; i < 4; i++)
			for (k = 0; k < 3; k++)
			begin
				ev = 5'(5'h11 + i * 3 + k);
				@(posedge clk_sys);
				pkt_speed <= SPD[k];
				pkt_event <= ev;
				pulse(2, 4'h1 << i);
				exp_v = {27'h000_0000, ev} | ((i >= 2) ? {24'h00_0000, SPD[k], 5'h00} : 32'h0);
				`CHK(ctx_wake[i], 1'b0)
				rd_chk(SET_A[i], exp_v);
			end
		$display("test speed done");
		// pointer value, outputs and count-zero invalid
		for (i = 0; i < 4; i++)
		begin
			exp_v = {24'h87_6543, 4'(i), 4'(i + 1)};
			wr(SET_A[i] + 12'h00c, exp_v);
			rd_chk(SET_A[i] + 12'h00c, exp_v);
			`CHK(ptr_o[i], exp_v)
			`CHK(ptr_valid[i], 1'b1)
			wr(SET_A[i] + 12'h00c, exp_v & 32'hffff_fff0);
			`CHK(ptr_valid[i], 1'b0)
		end
		$display("test pointer done");
		// software reset drops run and wake; unmapped place reads zero
		wr(SET_A[1], RUN | WAKE);
		pulse(3, 4'h1);
		`CHK(ctx_run, 4'h0)
		`CHK(ctx_wake, 4'h0)
		wr(12'h100, 32'hffff_ffff);
		rd_chk(12'h100, ADC_ZERO);
		$display("test soft reset done");
		// hardware reset in mid-run drops run and restores the pointer
		wr(SET_A[2], RUN | WAKE);
		@(posedge clk_sys);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		#1;
		`CHK(ctx_run, 4'h0)
		`CHK(ctx_wake, 4'h0)
		`CHK(ptr_o[2], ADC_PTR_RESET)
		rd_chk(SET_A[2], ADC_ZERO);
		$display("test hard reset done");
		give_verdict();
	end
endmodule
